// ### dv/bp_model.sv
// Backplane partner: free-running bit clock, frame sync and slot pattern
`timescale 1ns/1ps
module bp_model (
  // Backplane pins
  output logic bp_clk,
  output logic bp_fs_n,
  output logic [31:0] bp_din,
  // Position of the bit now on the wire
  output logic [9:0] pos
);
  logic [9:0] nxt;
  logic [7:0] slot_byte;
  initial begin
    bp_clk = 1'b0;
    bp_fs_n = 1'b1;
    bp_din = '0;
    pos = '0;
  end
  always #200 bp_clk = ~bp_clk;
  assign nxt = pos + 10'h001;
  assign slot_byte = {1'b0, nxt[9:3]} ^ 8'ha5;
  // Falling edge change keeps the sampled bit settled
  always @(negedge bp_clk) begin
    pos <= nxt;
    bp_fs_n <= (nxt != 10'h3ff);
    bp_din <= {32{slot_byte[3'h7 - nxt[2:0]]}};
  end
endmodule

// ### dv/tdm_route_switch_tb.sv
// Self-checking bench for TDM stream and transmit routing
`timescale 1ns/1ps
module tdm_route_switch_tb;
  import tdm_sw_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, bp_clk, bp_fs_n;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [9:0] bpos;
  logic [NSTR-1:0] bp_din, bp_dout, bp_doe;
  logic loc_si_valid, loc_so_valid;
  logic [CH_W-1:0] loc_si_chan, loc_so_chan;
  logic [BYTE_W-1:0] loc_si_byte, loc_so_byte;
  logic [NSTR-1:0] ob [1024];
  logic [NSTR-1:0] oe [1024];
  int n_fail, checked, cyc;
  tdm_route_switch u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .bp_clk, .bp_fs_n, .bp_din, .bp_dout, .bp_doe, .loc_si_valid,
    .loc_si_chan, .loc_si_byte, .loc_so_valid, .loc_so_chan, .loc_so_byte);
  bp_model u_bp (.bp_clk, .bp_fs_n, .bp_din, .pos(bpos));
  initial aclk = 1'b0;
  always #25 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Responses are always accepted, so bready and rready stay high
  task automatic wr(input logic [IDX_W-1:0] i, input logic [31:0] d, input logic [1:0] er);
    awaddr <= {i, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk(32'(bresp), 32'(er));
  endtask
  task automatic rd(input logic [IDX_W-1:0] i, input logic [31:0] ed, input logic [1:0] er);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    chk(rdata, ed);
    chk(32'(rresp), 32'(er));
  endtask
  task automatic loc(input logic [7:0] c, input logic [7:0] bs, input logic [7:0] bo);
    {loc_si_valid, loc_so_valid} <= 2'h3;
    {loc_si_chan, loc_so_chan, loc_si_byte, loc_so_byte} <= {c, c, bs, bo};
    @(posedge aclk);
    {loc_si_valid, loc_so_valid} <= 2'h0;
    @(posedge aclk);
  endtask
  // Skip a settling frame, then record one whole frame of every stream
  task automatic cap;
    repeat (2) begin
      do @(posedge bp_clk); while (bpos != 10'h000);
    end
    for (int i = 0; i < 1024; i++) begin
      ob[i] = bp_dout;
      oe[i] = bp_doe;
      @(posedge bp_clk);
    end
  endtask
  function automatic logic [31:0] slot(input int j, input int w, input int s);
    logic [8:0] v;
    v = 9'h100;
    for (int b = 0; b < 8; b++) begin
      v[7-b] = ob[(j*8+b)*w][s];
      v[8] = v[8] & oe[(j*8+b)*w][s];
    end
    return 32'(v);
  endfunction
  function automatic logic [7:0] src(input int n);
    return 8'(n) ^ 8'ha5;
  endfunction
  // Slow-rate reading of the fast pattern: last bit of every group of four
  function automatic logic [7:0] fold(input int n);
    logic [7:0] v, t;
    v = '0;
    for (int b = 0; b < 8; b++) begin
      t = src(4 * n + b / 2);
      v[7-b] = t[4 - 4 * (b % 2)];
    end
    return v;
  endfunction
  // Transmit channels own slots 8, 28, 40 of the 8 Mb/s grid
  function automatic logic [31:0] ex(input int j, input int sh, input logic [7:0] d);
    return 32'({1'b1, j == (8 >> sh) ? 8'h3c : j == (28 >> sh) ? 8'h77 :
      j == (40 >> sh) ? 8'he1 : d});
  endfunction
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk(32'(bp_doe), 32'h0000_0000);
    rd(IDX_ID0, 32'({MAKER_ID[6:0], BSCAN_CAP}), RESP_OKAY);
    rd(IDX_ID1, 32'({PART_LO, MAKER_ID[10:7]}), RESP_OKAY);
    rd(IDX_SS + 16'h0007, 32'h0000_0000, RESP_OKAY);
    rd(IDX_TX + 16'h00ff, 32'h0000_0000, RESP_OKAY);
  endtask
  task automatic t_rsvd;
    wr(IDX_SS + 16'h0001, 32'hffff_ffff, RESP_OKAY);
    rd(IDX_SS + 16'h0001, ~SS_RSVD, RESP_OKAY);
    wr(IDX_TX + 16'h0003, 32'hffff_ffff, RESP_OKAY);
    rd(IDX_TX + 16'h0003, ~TX_RSVD, RESP_OKAY);
    wr(IDX_SS + 16'h0001, 32'h0000_0000, RESP_OKAY);
    wr(IDX_TX + 16'h0003, 32'h0000_0000, RESP_OKAY);
    wr(IDX_ID0, 32'hffff_ffff, RESP_OKAY);
    rd(IDX_ID0, 32'({MAKER_ID[6:0], BSCAN_CAP}), RESP_OKAY);
    rd(16'h0200, 32'h0000_0000, RESP_SLVERR);
    wr(16'h0300, 32'h0000_0001, RESP_SLVERR);
  endtask
  task automatic t_route8;
    wr(IDX_SS, 32'h0000_8502, RESP_OKAY);
    wr(IDX_TX, 32'h0000_8508, RESP_OKAY);
    wr(IDX_TX + 16'h0001, 32'h0002_851c, RESP_OKAY);
    wr(IDX_TX + 16'h0002, 32'h0004_8528, RESP_OKAY);
    wr(IDX_PAR + 16'h0002, 32'h0000_00e1, RESP_OKAY);
    loc(8'h00, 8'h3c, 8'h00);
    loc(8'h01, 8'h11, 8'h77);
    cap();
    for (int j = 0; j < 128; j++) begin
      chk(slot(j, 1, 5), ex(j, 0, src((j + 127) % 128)));
    end
  endtask
  task automatic t_down;
    wr(IDX_RATE, 32'haaaa_a2aa, RESP_OKAY);
    wr(IDX_SS, 32'h0002_8502, RESP_OKAY);
    wr(IDX_SS + 16'h0001, 32'h0001_8405, RESP_OKAY);
    cap();
    for (int j = 0; j < 32; j++) begin
      chk(slot(j, 4, 5), ex(j, 2, src(4 * ((j + 31) % 32) + 2)));
    end
    // Partition 1 from the slow stream: only fast slots 4n+5 carry data
    for (int k = 0; k < 128; k++) begin
      chk(slot(k, 1, 4), (k % 4 == 1) ? 32'({1'b1, fold((k / 4 + 31) % 32)}) : '0);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {aresetn, awvalid, wvalid, arvalid, loc_si_valid, loc_so_valid} = '0;
    {bready, rready, wstrb} = 6'h3f;
    {awaddr, araddr, wdata, loc_si_chan, loc_so_chan, loc_si_byte, loc_so_byte} = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_rsvd();
    t_route8();
    t_down();
    results();
  end
  // Whole run needs about six frames of 8192 cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_fail++;
      results();
    end
  end
endmodule

// ### hdl/stream_slot_switch.sv
// One stream-switch channel: single-slot buffer with rate conversion
`timescale 1ns/1ps
module stream_slot_switch
  import tdm_sw_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Backplane timing and selected input bit
  input wire logic tick,
  input wire logic [BPOS_W-1:0] bpos,
  input wire logic din,
  // Routing
  input wire logic [1:0] in_rate,
  input wire logic [1:0] out_rate,
  input wire logic [PART_W-1:0] part,
  input wire logic en,
  // Output slot bit
  output logic drv,
  output logic dbit
);
  logic [1:0] ish, osh, dsh;
  logic [BPOS_W-1:0] imask;
  logic in_last, ok;
  logic [2:0] ibit, obit;
  logic [SLOT_W-1:0] islot, oslot, omask, tgt;
  logic [6:0] sh_r;
  logic [BYTE_W-1:0] hold_r;
  logic [SLOT_W-1:0] tgt_r;
  logic full_r;
  logic [BYTE_W-1:0] out_r;
  logic [SLOT_W-1:0] otgt_r;
  logic ovld_r, live;

  always_comb begin
    ish = RATE_8M - in_rate;
    osh = RATE_8M - out_rate;
    imask = (BPOS_W'(1) << ish) - BPOS_W'(1);
    in_last = (bpos & imask) == imask;
    ibit = 3'(bpos >> ish);
    obit = 3'(bpos >> osh);
    islot = SLOT_W'(bpos >> (BYTE_SH + 4'(ish)));
    oslot = SLOT_W'(bpos >> (BYTE_SH + 4'(osh)));
    omask = SLOT_W'((SLOTS_2M << out_rate) - 8'h01);
    ok = 1'b1;
    dsh = '0;
    if (in_rate == out_rate) begin
      tgt = islot + SLOT_W'(1);
    end else if (out_rate > in_rate) begin
      dsh = out_rate - in_rate;
      tgt = ((islot + SLOT_W'(1)) << dsh) + SLOT_W'(part);
    end else begin
      dsh = in_rate - out_rate;
      ok = (islot & ((SLOT_W'(1) << dsh) - SLOT_W'(1))) == SLOT_W'(part);
      tgt = (islot >> dsh) + SLOT_W'(1);
    end
    tgt = tgt & omask;
  end

  // Only one slot is held; a new slot overwrites it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sh_r <= '0;
      hold_r <= '0;
      tgt_r <= '0;
      full_r <= 1'b0;
    end else if (tick && in_last) begin
      sh_r <= {sh_r[5:0], din};
      if (&ibit && ok) begin
        hold_r <= {sh_r, din};
        tgt_r <= tgt;
        full_r <= 1'b1;
      end
    end
  end

  assign live = full_r && (oslot == tgt_r);

  // Down-conversion lands the next byte mid-slot; the snapshot keeps the slot whole
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_r <= '0;
      otgt_r <= '0;
      ovld_r <= 1'b0;
    end else if (live) begin
      out_r <= hold_r;
      otgt_r <= tgt_r;
      ovld_r <= 1'b1;
    end
  end

  assign drv = en && (live || (ovld_r && (oslot == otgt_r)));
  assign dbit = live ? hold_r[~obit] : out_r[~obit];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence slot_end_s;
    tick && in_last && (&ibit);
  endsequence
  same_rate_map_a: assert property (slot_end_s ##0 (in_rate == out_rate)
    |=> tgt_r == (($past(islot) + SLOT_W'(1)) & $past(omask)))
    else $error("same-rate slot not moved to next slot");
  up_map_a: assert property (slot_end_s ##0 (in_rate == RATE_2M && out_rate == RATE_8M)
    |=> tgt_r == SLOT_W'({$past(islot) + SLOT_W'(1), $past(part)}))
    else $error("2 to 8 up-conversion slot wrong");
  down_skip_a: assert property (slot_end_s ##0 !ok |=> $stable(hold_r))
    else $error("slot outside partition was carried");
endmodule

// ### hdl/tdm_route_switch.sv
// Stream switch and transmit switch routing with AXI4-Lite registers
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
// How it works
// - Identity byte zero bit 0 reports boundary-scan support.
// - Eleven-bit maker code split over identity bytes; part nibble in byte one top.
// - Reserved routing bits are written as zero and always read back zero.
// - Stream-switch source stream chosen by five-bit field, reset to stream 0.
// - Stream-switch destination field, reset 0; drives only when its enable bit is set.
// - Two-bit partition picks which slots take part in rate conversion.
// - Equal rates: input slot n goes to output slot n+1, wrapping.
// - Up-conversion by k: slot n goes to k*(n+1)+partition, wrapped.
// - Down-conversion by k: only slots k*m+partition carried, to slot m+1.
// - Eight independent channels, each joining any two of 32 streams.
// - One slot buffered at a time; no per-slot tri-state control.
// - Together the channels give 256 to 1024 one-way slot connections.
// - Transmit switch wins over stream switch in any shared slot.
// - Transmit output slot is seven bits on the 128-slot 8 Mb/s grid.
// - Transmit output stream chosen by five-bit field, reset to stream 0.
// - Transmit enable bit gates driving; resets to disabled.
// - Delay bit: 0 switches at frame start, 1 at 2 Mb/s slot boundaries.
// - Bus-connect bit takes local serial output instead of local serial input.
// - Source bit picks serial data at 0, parallel register at 1.
module tdm_route_switch
  import tdm_sw_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Backplane
  input wire logic bp_clk,
  input wire logic bp_fs_n,
  input wire logic [NSTR-1:0] bp_din,
  output logic [NSTR-1:0] bp_dout,
  output logic [NSTR-1:0] bp_doe,
  // Local serial bytes per transmit channel
  input wire logic loc_si_valid,
  input wire logic [CH_W-1:0] loc_si_chan,
  input wire logic [BYTE_W-1:0] loc_si_byte,
  input wire logic loc_so_valid,
  input wire logic [CH_W-1:0] loc_so_chan,
  input wire logic [BYTE_W-1:0] loc_so_byte
);
  typedef enum logic [1:0] {W_IDLE = 2'b01, W_RESP = 2'b10} wr_st_e;
  typedef enum logic [1:0] {R_IDLE = 2'b01, R_DATA = 2'b10} rd_st_e;
  typedef enum logic [2:0] {
    REG_NONE, REG_ID0, REG_ID1, REG_RATE, REG_SS, REG_TX, REG_PAR
  } region_e;

  function automatic region_e region_of(input logic [IDX_W-1:0] idx);
    region_e r;
    r = REG_NONE;
    if (idx == IDX_ID0) r = REG_ID0;
    else if (idx == IDX_ID1) r = REG_ID1;
    else if ((idx & ~RATE_SPAN) == IDX_RATE) r = REG_RATE;
    else if ((idx & ~SS_SPAN) == IDX_SS) r = REG_SS;
    else if ((idx & ~TX_SPAN) == IDX_TX) r = REG_TX;
    else if ((idx & ~TX_SPAN) == IDX_PAR) r = REG_PAR;
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Routing state
  logic [SEL_W-1:0] ss_in [NSS];
  logic [SEL_W-1:0] ss_out [NSS];
  logic ss_oe [NSS];
  logic [PART_W-1:0] ss_part [NSS];
  logic [SLOT_W-1:0] tx_slot [NTX];
  logic [SEL_W-1:0] tx_str [NTX];
  logic tx_oe [NTX];
  logic tx_dly [NTX];
  logic tx_bcon [NTX];
  logic tx_src [NTX];
  logic [BYTE_W-1:0] tx_buf [NTX];
  logic [BYTE_W-1:0] tx_out [NTX];
  logic [1:0] rate [NSTR];

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  wr_st_e wst_r;
  rd_st_e rst_r;
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r, wdata_r, rd_word;
  logic [3:0] wstrb_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [IDX_W-1:0] widx, ridx;
  logic [CH_W-1:0] wch, rch;
  region_e wreg, rreg;
  logic do_wr, rd_take;

  assign widx = aw_addr_r[ADDR_W-1:2];
  assign ridx = araddr[ADDR_W-1:2];
  assign wch = widx[CH_W-1:0];
  assign rch = ridx[CH_W-1:0];
  assign wreg = region_of(widx);
  assign rreg = region_of(ridx);
  assign do_wr = (wst_r == W_IDLE) && !awready_r && !wready_r;
  assign rd_take = arvalid && arready_r;

  // Address and data are taken in either order, then held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      aw_addr_r <= '0;
    end else if (awvalid && awready_r) begin
      awready_r <= 1'b0;
      aw_addr_r <= awaddr;
    end else if (bvalid_r && bready) begin
      awready_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_r <= 1'b1;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (wvalid && wready_r) begin
      wready_r <= 1'b0;
      wdata_r <= wdata;
      wstrb_r <= wstrb;
    end else if (bvalid_r && bready) begin
      wready_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_r <= W_IDLE;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      case (wst_r)
        W_IDLE: if (do_wr) begin
          wst_r <= W_RESP;
          bvalid_r <= 1'b1;
          bresp_r <= (wreg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        W_RESP: if (bready) begin
          wst_r <= W_IDLE;
          bvalid_r <= 1'b0;
        end
        default: wst_r <= W_IDLE;
      endcase
    end
  end

  // Reserved bits are never stored, so they read back as zero
  always_comb begin
    rd_word = '0;
    if (rreg == REG_ID0) begin
      rd_word[BYTE_W-1:0] = {MAKER_ID[6:0], BSCAN_CAP};
    end else if (rreg == REG_ID1) begin
      rd_word[BYTE_W-1:0] = {PART_LO, MAKER_ID[10:7]};
    end else if (rreg == REG_RATE) begin
      for (int b = 0; b < RATES_PER_WORD; b++)
        rd_word[2*b +: 2] = rate[RATES_PER_WORD*int'(rch[0]) + b];
    end else if (rreg == REG_SS) begin
      rd_word[SEL_W-1:0] = ss_in[rch[2:0]];
      rd_word[B1_LSB +: SEL_W] = ss_out[rch[2:0]];
      rd_word[OE_BIT] = ss_oe[rch[2:0]];
      rd_word[B2_LSB +: PART_W] = ss_part[rch[2:0]];
    end else if (rreg == REG_TX) begin
      rd_word[SLOT_W-1:0] = tx_slot[rch];
      rd_word[B1_LSB +: SEL_W] = tx_str[rch];
      rd_word[OE_BIT] = tx_oe[rch];
      rd_word[DLY_BIT] = tx_dly[rch];
      rd_word[BCON_BIT] = tx_bcon[rch];
      rd_word[SRC_BIT] = tx_src[rch];
    end else if (rreg == REG_PAR) begin
      rd_word[BYTE_W-1:0] = tx_buf[rch];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_r <= R_IDLE;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else begin
      case (rst_r)
        R_IDLE: if (rd_take) begin
          rst_r <= R_DATA;
          arready_r <= 1'b0;
          rvalid_r <= 1'b1;
          rdata_r <= rd_word;
          rresp_r <= (rreg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        R_DATA: if (rready) begin
          rst_r <= R_IDLE;
          arready_r <= 1'b1;
          rvalid_r <= 1'b0;
        end
        default: rst_r <= R_IDLE;
      endcase
    end
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  ////////////////////////////////////////////////////////////////////////
  // Routing register writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NSS; i++) begin
        ss_in[i] <= '0;
        ss_out[i] <= '0;
        ss_oe[i] <= 1'b0;
        ss_part[i] <= '0;
      end
      for (int i = 0; i < NTX; i++) begin
        tx_slot[i] <= '0;
        tx_str[i] <= '0;
        tx_oe[i] <= 1'b0;
        tx_dly[i] <= 1'b0;
        tx_bcon[i] <= 1'b0;
        tx_src[i] <= 1'b0;
      end
      for (int i = 0; i < NSTR; i++)
        rate[i] <= RATE_RST;
    end else if (do_wr) begin
      if (wreg == REG_SS) begin
        if (wstrb_r[0])
          ss_in[wch[2:0]] <= wdata_r[SEL_W-1:0];
        if (wstrb_r[1]) begin
          ss_out[wch[2:0]] <= wdata_r[B1_LSB +: SEL_W];
          ss_oe[wch[2:0]] <= wdata_r[OE_BIT];
        end
        if (wstrb_r[2])
          ss_part[wch[2:0]] <= wdata_r[B2_LSB +: PART_W];
      end else if (wreg == REG_TX) begin
        if (wstrb_r[0])
          tx_slot[wch] <= wdata_r[SLOT_W-1:0];
        if (wstrb_r[1]) begin
          tx_str[wch] <= wdata_r[B1_LSB +: SEL_W];
          tx_oe[wch] <= wdata_r[OE_BIT];
        end
        if (wstrb_r[2]) begin
          tx_dly[wch] <= wdata_r[DLY_BIT];
          tx_bcon[wch] <= wdata_r[BCON_BIT];
          tx_src[wch] <= wdata_r[SRC_BIT];
        end
      end else if (wreg == REG_RATE) begin
        for (int b = 0; b < RATES_PER_WORD; b++)
          if (wstrb_r[b/4])
            rate[RATES_PER_WORD*int'(wch[0]) + b] <= wdata_r[2*b +: 2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Backplane timing: pins pass two flops before use
  logic clk_s1, clk_s2, clk_s3, fs_s1, fs_s2;
  logic [NSTR-1:0] din_s1, din_s2;
  logic [BPOS_W-1:0] bpos_r, bpos_nxt;
  logic tick, frame_edge, slot2m_edge;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {clk_s1, clk_s2, clk_s3} <= '0;
      {fs_s1, fs_s2} <= 2'b11;
      din_s1 <= '0;
      din_s2 <= '0;
    end else begin
      {clk_s1, clk_s2, clk_s3} <= {bp_clk, clk_s1, clk_s2};
      {fs_s1, fs_s2} <= {bp_fs_n, fs_s1};
      din_s1 <= bp_din;
      din_s2 <= din_s1;
    end
  end

  assign tick = clk_s2 && !clk_s3;
  assign frame_edge = tick && !fs_s2;
  assign bpos_nxt = !fs_s2 ? '0 : bpos_r + BPOS_W'(1);
  assign slot2m_edge = tick && (bpos_nxt[B2M_W-1:0] == '0);

  // 1024 bit times give 128 slots of 8 bits each
  always_ff @(posedge aclk) begin
    if (!aresetn)
      bpos_r <= '0;
    else if (tick)
      bpos_r <= bpos_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit buffers; serial and parallel share one byte per channel
  logic par_wr;
  assign par_wr = do_wr && (wreg == REG_PAR) && wstrb_r[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int c = 0; c < NTX; c++)
        tx_buf[c] <= '0;
    end else begin
      for (int c = 0; c < NTX; c++) begin
        if (tx_src[c]) begin
          if (par_wr && wch == CH_W'(c))
            tx_buf[c] <= wdata_r[BYTE_W-1:0];
        end else if (tx_bcon[c]) begin
          if (loc_so_valid && loc_so_chan == CH_W'(c))
            tx_buf[c] <= loc_so_byte;
        end else if (loc_si_valid && loc_si_chan == CH_W'(c)) begin
          tx_buf[c] <= loc_si_byte;
        end
      end
    end
  end

  // Constant delay keeps a whole frame bundled; minimum trades that away
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int c = 0; c < NTX; c++)
        tx_out[c] <= '0;
    end else begin
      for (int c = 0; c < NTX; c++)
        if (tx_dly[c] ? slot2m_edge : frame_edge)
          tx_out[c] <= tx_buf[c];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stream switch channels
  logic [NSS-1:0] ss_drv, ss_dbit;

  for (genvar k = 0; k < NSS; k++) begin : g_ss
    stream_slot_switch u_ch (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(tick),
      .bpos(bpos_r),
      .din(din_s2[ss_in[k]]),
      .in_rate(rate[ss_in[k]]),
      .out_rate(rate[ss_out[k]]),
      .part(ss_part[k]),
      .en(ss_oe[k]),
      .drv(ss_drv[k]),
      .dbit(ss_dbit[k])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-stream output; lowest transmit channel wins among duplicates
  logic [NSTR-1:0] tx_hit, tx_bitv, ss_hit, ss_bitv;

  always_comb begin
    logic [1:0] sh;
    logic [SLOT_W-1:0] sslot;
    logic [2:0] sbit;
    sh = '0;
    sslot = '0;
    sbit = '0;
    tx_hit = '0;
    tx_bitv = '0;
    ss_hit = '0;
    ss_bitv = '0;
    for (int s = 0; s < NSTR; s++) begin
      sh = RATE_8M - rate[s];
      sslot = SLOT_W'(bpos_r >> (BYTE_SH + 4'(sh)));
      sbit = 3'(bpos_r >> sh);
      for (int c = NTX - 1; c >= 0; c--) begin
        if (tx_oe[c] && tx_str[c] == SEL_W'(s) && (tx_slot[c] >> sh) == sslot) begin
          tx_hit[s] = 1'b1;
          tx_bitv[s] = tx_out[c][~sbit];
        end
      end
      for (int k = 0; k < NSS; k++) begin
        if (ss_drv[k] && ss_out[k] == SEL_W'(s)) begin
          ss_hit[s] = 1'b1;
          ss_bitv[s] = ss_dbit[k];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bp_dout <= '0;
      bp_doe <= '0;
    end else begin
      bp_dout <= (tx_hit & tx_bitv) | (~tx_hit & ss_bitv);
      bp_doe <= tx_hit | ss_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  frame_start_a: assert property (frame_edge |=> bpos_r == '0)
    else $error("bit position not cleared at frame start");
  id_bscan_a: assert property (rd_take && rreg == REG_ID0
    |=> rvalid_r && rdata_r[0] == BSCAN_CAP)
    else $error("boundary-scan bit wrong");
  id_maker_a: assert property (rd_take && rreg == REG_ID1
    |=> rdata_r[BYTE_W-1:0] == {PART_LO, MAKER_ID[10:7]})
    else $error("maker code high bits wrong");
  ss_rsvd_a: assert property (rd_take && rreg == REG_SS
    |=> (rdata_r & SS_RSVD) == '0)
    else $error("stream-switch reserved bits not zero");
  tx_rsvd_a: assert property (rd_take && rreg == REG_TX
    |=> (rdata_r & TX_RSVD) == '0)
    else $error("transmit reserved bits not zero");
  tx_wins_a: assert property (|(tx_hit & ss_hit)
    |=> (bp_dout & $past(tx_hit)) == ($past(tx_bitv) & $past(tx_hit)))
    else $error("stream switch overrode transmit switch");
  drive_gate_a: assert property (1'b1 |=> bp_doe == $past(tx_hit | ss_hit))
    else $error("stream driven without an enabled channel");
  write_resp_a: assert property (do_wr |=> bvalid_r ##0 !awready_r [*1])
    else $error("write not answered");
endmodule

// ### pkg/tdm_sw_pkg.sv
// Shared constants and types for the TDM stream and transmit switch
package tdm_sw_pkg;
  localparam int NSTR = 32;
  localparam int NSS = 8;
  localparam int NTX = 256;
  localparam int ADDR_W = 18;
  localparam int IDX_W = 16;
  localparam int BPOS_W = 10;
  localparam int SLOT_W = 7;
  localparam int SEL_W = 5;
  localparam int PART_W = 2;
  localparam int BYTE_W = 8;
  localparam int CH_W = 8;
  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_ID0 = 16'h00fc;
  localparam logic [IDX_W-1:0] IDX_ID1 = 16'h00fd;
  localparam logic [IDX_W-1:0] IDX_RATE = 16'h0100;
  localparam logic [IDX_W-1:0] IDX_SS = 16'h1000;
  localparam logic [IDX_W-1:0] IDX_TX = 16'h2000;
  localparam logic [IDX_W-1:0] IDX_PAR = 16'h4000;
  localparam logic [IDX_W-1:0] RATE_SPAN = 16'h0001;
  localparam logic [IDX_W-1:0] SS_SPAN = 16'h0007;
  localparam logic [IDX_W-1:0] TX_SPAN = 16'h00ff;
  // Routing word: byte 0, byte 1, byte 2 in lanes 0..2
  localparam int B1_LSB = 8;
  localparam int B2_LSB = 16;
  localparam int OE_BIT = 15;
  localparam int DLY_BIT = 16;
  localparam int BCON_BIT = 17;
  localparam int SRC_BIT = 18;
  localparam logic [31:0] SS_RSVD = 32'hfffc_60e0;
  localparam logic [31:0] TX_RSVD = 32'hfff8_6080;
  localparam int RATES_PER_WORD = 16;
  typedef enum logic [1:0] {
    RATE_2M = 2'h0,
    RATE_4M = 2'h1,
    RATE_8M = 2'h2
  } rate_e;
  localparam logic [1:0] RATE_RST = 2'h2;
  localparam logic [3:0] BYTE_SH = 4'h3;
  localparam logic [7:0] SLOTS_2M = 8'h20;
  localparam int B2M_W = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Identity fields; values are arbitrary
  localparam logic [10:0] MAKER_ID = 11'h155;
  localparam logic [3:0] PART_LO = 4'h5;
  localparam logic BSCAN_CAP = 1'b0;
endpackage
